// >>> pkg/clock_tick_timer_pkg.sv
// Purpose: Constants and types for the clock tick timer.
// Assumes: Core clock 25 MHz; slow oscillator 32.768 kHz.
// Notes: Behaviour list follows.
// Behaviour
// - 8-bit up-counter clocked by a 256 Hz tick divided from the 32.768 kHz oscillator; the code divides the tick from the 25 MHz core clock
// - Counter bits readable, bit 0 is 128 Hz up to bit 7 at 1 Hz
// - Falling edges of 32, 8, 2, 1 Hz taps set separate factor flags
// - Each factor flag has its own enable; disabled factors raise no request
// - Interrupt priority level 0 to 3 from two priority bits
// - 32 Hz factor vector 000032H, 8 Hz factor vector 000034H
// - 2 Hz factor vector 000036H, 1 Hz factor vector 000038H
// - Count register read-only, writes ignored, 00H after reset
// - Writing 1 to clear bit clears counter; 0 ignored; reads 0
// - Clear while running resumes from zero; while stopped holds 00H
// - Run bit 1 counts, 0 stops, readable
// - Stopped counter holds its value, resumes from it on run
// - Run bit is 0 after reset, counter stopped
// - Run bit change takes effect at next 256 Hz falling edge
// - After writing 0 counter increments once more at that edge, then stops
// - Run bit reads 1 until counter has really stopped
package clock_tick_timer_pkg;

	localparam logic [15:0] ADDR_CONTROL  = 16'hff40;
	localparam logic [15:0] ADDR_COUNT    = 16'hff41;
	localparam logic [15:0] ADDR_STATUS   = 16'hff42;
	localparam logic [15:0] ADDR_CLEAR    = 16'hff43;
	localparam logic [15:0] ADDR_ENABLE   = 16'hff44;
	localparam logic [15:0] ADDR_PRIORITY = 16'hff45;

	localparam int BIT_RUN   = 0;
	localparam int BIT_CLEAR = 1;

	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [3:0] FLAG_RESET  = 4'h0;
	localparam logic [3:0] ENABLE_RESET = 4'h0;
	localparam logic [1:0] PRIORITY_RESET = 2'h0;

	// Tap positions within the counter for each factor
	localparam int TAP_32HZ = 2;
	localparam int TAP_8HZ  = 4;
	localparam int TAP_2HZ  = 6;
	localparam int TAP_1HZ  = 7;

	localparam logic [23:0] VEC_32HZ = 24'h000032;
	localparam logic [23:0] VEC_8HZ  = 24'h000034;
	localparam logic [23:0] VEC_2HZ  = 24'h000036;
	localparam logic [23:0] VEC_1HZ  = 24'h000038;
	localparam logic [23:0] VEC_NONE = 24'h000000;

	localparam longint CORE_CLK_HZ = 25000000;
	localparam longint SLOW_OSC_HZ = 32768;
	localparam longint TICK_HZ     = 256;
	// Half period of the 256 Hz tick in core cycles, rounded down
	localparam int TICK_HALF_CYCLES = int'(CORE_CLK_HZ / (2 * TICK_HZ));

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

	typedef struct packed {
		logic        req;
		logic [1:0]  level;
		logic [23:0] vector;
	} irq_out_t;

endpackage : clock_tick_timer_pkg

// >>> hdl/clock_tick_timer.sv
// Purpose: Clock tick timer with 8-bit counter and four tick interrupt factors.
// Assumes: Single 25 MHz core clock; 256 Hz tick derived internally.
// Notes: Flags clear by writing 1 to the clear register; set wins over clear.
//
// Design decision made here: the address-and-strobe port.
module clock_tick_timer #(
	parameter int TICK_HALF = clock_tick_timer_pkg::TICK_HALF_CYCLES
) (
	input  wire logic                             i_core_clk,
	input  wire logic                             i_rst,
	input  wire clock_tick_timer_pkg::bus_req_t   i_bus,
	output logic [7:0]                            o_rdata,
	output logic                                  o_irq,
	output logic [3:0]                            o_irq_factor,
	output clock_tick_timer_pkg::irq_out_t        o_irq_info
);

	logic [31:0] div_cnt_q;
	logic        tick_q;
	logic        tick_fall;
	logic [7:0]  count_q;
	logic [7:0]  count_d;
	logic        run_req_q;
	logic        running_q;
	logic [3:0]  flags;
	logic [3:0]  enable;
	logic        count_step;
	logic        wr_clear_reg;
	logic        wr_enable_reg;
	logic        wr_prio_reg;
	logic [23:0] vec_d;
	logic [1:0]  prio_q;
	logic [3:0]  taps;
	logic [3:0]  taps_next;
	logic [3:0]  fall_set;
	logic [3:0]  active;
	logic        wr_ctl;
	logic        clear_wr;

	assign wr_ctl    = i_bus.wr && (i_bus.addr == clock_tick_timer_pkg::ADDR_CONTROL);
	assign clear_wr  = wr_ctl && i_bus.wdata[clock_tick_timer_pkg::BIT_CLEAR];
	assign wr_clear_reg  = i_bus.wr && (i_bus.addr == clock_tick_timer_pkg::ADDR_CLEAR);
	assign wr_enable_reg = i_bus.wr && (i_bus.addr == clock_tick_timer_pkg::ADDR_ENABLE);
	assign wr_prio_reg   = i_bus.wr && (i_bus.addr == clock_tick_timer_pkg::ADDR_PRIORITY);

	// 256 Hz tick: toggles every half period; counting happens on its falling edge
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			div_cnt_q <= 32'h0;
			tick_q    <= 1'b0;
		end
		else if (div_cnt_q == 32'(TICK_HALF - 1))
		begin
			div_cnt_q <= 32'h0;
			tick_q    <= ~tick_q;
		end
		else
		begin
			div_cnt_q <= div_cnt_q + 32'h1;
		end
	end

	assign tick_fall = tick_q && (div_cnt_q == 32'(TICK_HALF - 1));

	// Run request stored from software; running state follows at the tick edge
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			run_req_q <= 1'b0;
		end
		else if (wr_ctl)
		begin
			run_req_q <= i_bus.wdata[clock_tick_timer_pkg::BIT_RUN];
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			running_q <= 1'b0;
		end
		else if (tick_fall)
		begin
			running_q <= run_req_q;
		end
	end

	// Steps at the edge that starts running and at the edge that stops it
	assign count_step = tick_fall && (running_q || run_req_q) && !clear_wr;

	// A clear wins over a coinciding tick step, so no tap edge is faked by it
	always_comb
	begin
		count_d = count_q;
		if (clear_wr)
		begin
			count_d = clock_tick_timer_pkg::COUNT_RESET;
		end
		else if (count_step)
		begin
			count_d = count_q + 8'h01;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			count_q <= clock_tick_timer_pkg::COUNT_RESET;
		end
		else
		begin
			count_q <= count_d;
		end
	end

	assign taps      = {count_q[clock_tick_timer_pkg::TAP_1HZ], count_q[clock_tick_timer_pkg::TAP_2HZ],
	                    count_q[clock_tick_timer_pkg::TAP_8HZ], count_q[clock_tick_timer_pkg::TAP_32HZ]};
	assign taps_next = {count_d[clock_tick_timer_pkg::TAP_1HZ], count_d[clock_tick_timer_pkg::TAP_2HZ],
	                    count_d[clock_tick_timer_pkg::TAP_8HZ], count_d[clock_tick_timer_pkg::TAP_32HZ]};
	assign fall_set  = taps & ~taps_next & {4{count_step}};

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			prio_q <= clock_tick_timer_pkg::PRIORITY_RESET;
		end
		else if (wr_prio_reg)
		begin
			prio_q <= i_bus.wdata[1:0];
		end
	end

	// One flag, enable and request per factor: bit 0 is 32 Hz up to bit 3 at 1 Hz
	tick_factor_slot #(
		.FLAG_INIT   (clock_tick_timer_pkg::FLAG_RESET[0]),
		.ENABLE_INIT (clock_tick_timer_pkg::ENABLE_RESET[0])
	) i_factor_32hz (
		.i_core_clk   (i_core_clk),
		.i_rst        (i_rst),
		.i_fall       (fall_set[0]),
		.i_clear_wr   (wr_clear_reg),
		.i_clear_bit  (i_bus.wdata[0]),
		.i_enable_wr  (wr_enable_reg),
		.i_enable_bit (i_bus.wdata[0]),
		.o_flag       (flags[0]),
		.o_enable     (enable[0]),
		.o_request    (active[0])
	);

	tick_factor_slot #(
		.FLAG_INIT   (clock_tick_timer_pkg::FLAG_RESET[1]),
		.ENABLE_INIT (clock_tick_timer_pkg::ENABLE_RESET[1])
	) i_factor_8hz (
		.i_core_clk   (i_core_clk),
		.i_rst        (i_rst),
		.i_fall       (fall_set[1]),
		.i_clear_wr   (wr_clear_reg),
		.i_clear_bit  (i_bus.wdata[1]),
		.i_enable_wr  (wr_enable_reg),
		.i_enable_bit (i_bus.wdata[1]),
		.o_flag       (flags[1]),
		.o_enable     (enable[1]),
		.o_request    (active[1])
	);

	tick_factor_slot #(
		.FLAG_INIT   (clock_tick_timer_pkg::FLAG_RESET[2]),
		.ENABLE_INIT (clock_tick_timer_pkg::ENABLE_RESET[2])
	) i_factor_2hz (
		.i_core_clk   (i_core_clk),
		.i_rst        (i_rst),
		.i_fall       (fall_set[2]),
		.i_clear_wr   (wr_clear_reg),
		.i_clear_bit  (i_bus.wdata[2]),
		.i_enable_wr  (wr_enable_reg),
		.i_enable_bit (i_bus.wdata[2]),
		.o_flag       (flags[2]),
		.o_enable     (enable[2]),
		.o_request    (active[2])
	);

	tick_factor_slot #(
		.FLAG_INIT   (clock_tick_timer_pkg::FLAG_RESET[3]),
		.ENABLE_INIT (clock_tick_timer_pkg::ENABLE_RESET[3])
	) i_factor_1hz (
		.i_core_clk   (i_core_clk),
		.i_rst        (i_rst),
		.i_fall       (fall_set[3]),
		.i_clear_wr   (wr_clear_reg),
		.i_clear_bit  (i_bus.wdata[3]),
		.i_enable_wr  (wr_enable_reg),
		.i_enable_bit (i_bus.wdata[3]),
		.o_flag       (flags[3]),
		.o_enable     (enable[3]),
		.o_request    (active[3])
	);

	// Fastest tick wins when several factors are pending
	always_comb
	begin
		vec_d = clock_tick_timer_pkg::VEC_NONE;
		if (active[0])
		begin
			vec_d = clock_tick_timer_pkg::VEC_32HZ;
		end
		else if (active[1])
		begin
			vec_d = clock_tick_timer_pkg::VEC_8HZ;
		end
		else if (active[2])
		begin
			vec_d = clock_tick_timer_pkg::VEC_2HZ;
		end
		else if (active[3])
		begin
			vec_d = clock_tick_timer_pkg::VEC_1HZ;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_irq        <= 1'b0;
			o_irq_factor <= 4'h0;
		end
		else
		begin
			o_irq        <= |active;
			o_irq_factor <= active;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_irq_info <= '0;
		end
		else
		begin
			o_irq_info.req    <= |active;
			o_irq_info.level  <= prio_q;
			o_irq_info.vector <= vec_d;
		end
	end

	// Read data in the cycle after the read strobe; unmapped reads give zero
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_rdata <= 8'h00;
		end
		else if (i_bus.rd)
		begin
			unique case (i_bus.addr)
				clock_tick_timer_pkg::ADDR_CONTROL:
					o_rdata <= {7'h00, run_req_q | running_q};
				clock_tick_timer_pkg::ADDR_COUNT:
					o_rdata <= count_q;
				clock_tick_timer_pkg::ADDR_STATUS:
					o_rdata <= {4'h0, flags};
				clock_tick_timer_pkg::ADDR_CLEAR:
					o_rdata <= 8'h00;
				clock_tick_timer_pkg::ADDR_ENABLE:
					o_rdata <= {4'h0, enable};
				clock_tick_timer_pkg::ADDR_PRIORITY:
					o_rdata <= {6'h00, prio_q};
				default:
					o_rdata <= 8'h00;
			endcase
		end
		else
		begin
			o_rdata <= 8'h00;
		end
	end

endmodule : clock_tick_timer

// One interrupt factor: sticky flag, its enable bit and the request they make
module tick_factor_slot #(
	parameter logic FLAG_INIT   = 1'b0,
	parameter logic ENABLE_INIT = 1'b0
) (
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_fall,
	input  wire logic i_clear_wr,
	input  wire logic i_clear_bit,
	input  wire logic i_enable_wr,
	input  wire logic i_enable_bit,
	output logic      o_flag,
	output logic      o_enable,
	output logic      o_request
);

	// A tap edge in the same cycle as a clear keeps the flag set
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_flag <= FLAG_INIT;
		end
		else if (i_fall)
		begin
			o_flag <= 1'b1;
		end
		else if (i_clear_wr && i_clear_bit)
		begin
			o_flag <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_enable <= ENABLE_INIT;
		end
		else if (i_enable_wr)
		begin
			o_enable <= i_enable_bit;
		end
	end

	assign o_request = o_flag && o_enable;

endmodule : tick_factor_slot

// >>> verification/clock_tick_timer_assertions.sv
// Purpose: Port assertions for the clock tick timer.
// Assumes: All signals sampled on the rising core clock.
// Notes: Bound to every timer instance.
module clock_tick_timer_assertions (
	input wire logic                           i_core_clk,
	input wire logic                           i_rst,
	input wire clock_tick_timer_pkg::bus_req_t i_bus,
	input wire logic [7:0]                     o_rdata,
	input wire logic                           o_irq,
	input wire logic [3:0]                     o_irq_factor,
	input wire clock_tick_timer_pkg::irq_out_t o_irq_info
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	chk_irq_any_factor:
	assert property (o_irq == (o_irq_factor != 4'h0)) else $error("irq level");
	chk_req_tracks_irq:
	assert property (o_irq_info.req == o_irq) else $error("req differs from irq");
	chk_vec_fast:
	assert property (o_irq_factor[0] |-> o_irq_info.vector == 24'h000032) else $error("vec 32");
	chk_vec_eight:
	assert property (o_irq_factor[1:0] == 2'b10 |-> o_irq_info.vector == 24'h000034)
		else $error("vec 8");
	chk_vec_two:
	assert property (o_irq_factor[2:0] == 3'b100 |-> o_irq_info.vector == 24'h000036)
		else $error("vec 2");
	chk_vec_one:
	assert property (o_irq_factor == 4'b1000 |-> o_irq_info.vector == 24'h000038)
		else $error("vec 1");
	chk_rdata_idle:
	assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00) else $error("rdata idle");
	chk_ctrl_clear_zero:
	assert property (i_bus.rd && i_bus.addr == 16'hff40 |=> o_rdata[7:1] == 7'h00)
		else $error("ctrl upper");
	chk_flag_clear_wo:
	assert property (i_bus.rd && i_bus.addr == 16'hff43 |=> o_rdata == 8'h00)
		else $error("clear reg");
	cover property ($rose(o_irq));
	cover property (o_irq_factor == 4'hf);
	cover property (i_bus.wr && i_bus.addr == 16'hff43);
endmodule : clock_tick_timer_assertions

bind clock_tick_timer clock_tick_timer_assertions i_chk (.i_core_clk(i_core_clk),
	.i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata), .o_irq(o_irq),
	.o_irq_factor(o_irq_factor), .o_irq_info(o_irq_info));

// >>> verification/clock_tick_timer_bench.sv
// Purpose: Self-checking bench for the clock tick timer.
// Assumes: Tick half period cut to 4 core cycles.
// Notes: Registers reached by one-cycle strobes.
module clock_tick_timer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                           clk;
	logic                           rst;
	clock_tick_timer_pkg::bus_req_t bus;
	logic [7:0]                     rdata;
	logic                           irq;
	logic [3:0]                     fac;
	clock_tick_timer_pkg::irq_out_t info;
	int                             fail_count;
	int                             checked;
	logic [7:0]                     v;
	logic [7:0]                     s;

	clock_tick_timer #(.TICK_HALF(4)) i_dut (.i_core_clk(clk), .i_rst(rst), .i_bus(bus),
		.o_rdata(rdata), .o_irq(irq), .o_irq_factor(fac), .o_irq_info(info));

	always #20 clk = ~clk;

	task automatic complete_run();
		$display("checks %0d errors %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checked++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk) bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a);
		@(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk) bus.rd <= 1'b0;
		@(negedge clk) v = rdata;
	endtask : rd

	task automatic rdc(input logic [15:0] a, input logic [7:0] e);
		rd(a);
		chk(v, e);
	endtask : rdc

	// Polls the count until it steps, so the next tick edge is far away
	task automatic sync();
		rd(16'hff41);
		s = v;
		for (int n = 0; n < 20 && v === s; n++)
			rd(16'hff41);
		if (v === s)
		begin
			fail_count++;
			$display("ERROR %0t count never stepped", $time);
			complete_run();
		end
	endtask : sync

	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		bus = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rdc(16'hff40, 8'h00);
		rdc(16'hff41, 8'h00);
		wr(16'hff41, 8'h5a);
		rdc(16'hff41, 8'h00);
		rdc(16'hff4f, 8'h00);
		repeat (40) @(posedge clk);
		rdc(16'hff41, 8'h00);
		wr(16'hff40, 8'h01);
		rdc(16'hff40, 8'h01);
		sync();
		s = v;
		wr(16'hff40, 8'h00);
		rdc(16'hff40, 8'h01);
		repeat (12) @(posedge clk);
		rdc(16'hff40, 8'h00);
		rdc(16'hff41, s + 8'h01);
		repeat (20) @(posedge clk);
		rdc(16'hff41, s + 8'h01);
		wr(16'hff40, 8'h01);
		sync();
		chk(v, s + 8'h01);
		wr(16'hff40, 8'h03);
		repeat (8) @(posedge clk);
		rd(16'hff41);
		s = v;
		chk(s <= 8'h02, 1);
		repeat (64) @(posedge clk);
		rd(16'hff41);
		chk(v - s inside {8'h08, 8'h09}, 1);
		wr(16'hff40, 8'h00);
		repeat (12) @(posedge clk);
		wr(16'hff40, 8'h02);
		repeat (12) @(posedge clk);
		rdc(16'hff41, 8'h00);
		rdc(16'hff40, 8'h00);
		wr(16'hff45, 8'h03);
		wr(16'hff40, 8'h01);
		repeat (2100) @(posedge clk);
		wr(16'hff40, 8'h00);
		repeat (12) @(posedge clk);
		rdc(16'hff42, 8'h0f);
		chk({irq, info.req}, 0);
		for (int i = 0; i < 4; i++)
		begin
			wr(16'hff44, 8'h01 << i);
			repeat (3) @(negedge clk);
			chk({irq, info.req, info.level, fac}, {2'b11, 2'h3, 4'h1 << i});
			chk(info.vector, 24'h000032 + 24'(2 * i));
		end
		wr(16'hff44, 8'h0f);
		wr(16'hff43, 8'h01);
		rdc(16'hff42, 8'h0e);
		repeat (3) @(negedge clk);
		chk(info.vector, 24'h000034);
		wr(16'hff43, 8'h0f);
		repeat (3) @(negedge clk);
		chk({irq, info.req}, 0);
		for (int i = 0; i < 4; i++)
		begin
			wr(16'hff45, i[7:0]);
			repeat (3) @(negedge clk);
			chk(info.level, i[1:0]);
		end
		complete_run();
	end
endmodule : clock_tick_timer_bench
